// [hw/urx_cfg.svh]
`ifndef URX_CFG_SVH
`define URX_CFG_SVH
`define URX_OFS_DATA   8'h00
`define URX_OFS_STAT   8'h04
`define URX_OFS_ISTAT  8'h10
`define URX_OFS_IMASK  8'h14
`define URX_OFS_LCTRL  8'h1c
`define URX_OFS_DIV    8'h20
`define URX_DW_FE      8
`define URX_DW_PE      9
`define URX_DW_BE      10
`define URX_DW_OE      11
`define URX_RS_OE      3
`define URX_LC_PEN     1
`define URX_LC_EPS     2
`define URX_LC_FEN     4
`define URX_LC_SPS     7
`define URX_LCTRL_RST  8'h00
`define URX_DIV_RST    16'h0878
`define URX_FIFO_DEPTH 5'h10
`define URX_PTR_W      4
`endif

// [hw/urx_data_status.sv]
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "urx_cfg.svh"
module urx_data_status (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rd_data,
  // serial line
  input  wire logic        rxd,
  // transmit side
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  // interrupt
  output logic             irq
);
  urx_rx_if rif ();

  logic [7:0]                  lctrl_q;
  logic [15:0]                 div_q;
  logic [3:0]                  imask_q;
  logic [3:0]                  istat_q;
  logic [3:0]                  rsr_q;
  logic                        oe_dw_q;
  urx_pkg::urx_entry_t         mem_q [0:15];
  logic [`URX_PTR_W-1:0]       wptr_q;
  logic [`URX_PTR_W-1:0]       rptr_q;
  logic [4:0]                  cnt_q;
  logic [31:0]                 rd_data_q;
  logic [31:0]                 rd_data_d;
  logic [7:0]                  tx_data_q;
  logic                        tx_valid_q;
  logic                        irq_q;
  urx_pkg::urx_entry_t         head;
  logic [4:0]                  depth;
  logic                        full;
  logic                        push;
  logic                        ovr;
  logic                        pop;
  logic                        clr_wr;
  logic [3:0]                  ev;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  urx_rx_core u_core (
    .clk     (clk),
    .sys_rst (sys_rst),
    .rxd     (rxd),
    .rif     (rif.rx)
  );

  assign rif.div = div_q;
  assign rif.pen = lctrl_q[`URX_LC_PEN];
  assign rif.eps = lctrl_q[`URX_LC_EPS];
  assign rif.sps = lctrl_q[`URX_LC_SPS];

  // without the queue enabled it acts as a single holding slot
  assign depth  = lctrl_q[`URX_LC_FEN] ? `URX_FIFO_DEPTH : 5'h01;
  assign full   = cnt_q >= depth;
  assign push   = rif.done && !full;
  assign ovr    = rif.done && full;
  assign pop    = rd_en && hit(addr, `URX_OFS_DATA) && cnt_q != 5'h00;
  assign clr_wr = wr_en && hit(addr, `URX_OFS_STAT);
  assign head   = mem_q[rptr_q];
  assign ev     = {ovr, rif.done & rif.ent.be, rif.done & rif.ent.pe, rif.done & rif.ent.fe};

  assign rd_data  = rd_data_q;
  assign tx_data  = tx_data_q;
  assign tx_valid = tx_valid_q;
  assign irq      = irq_q;

  // configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lctrl_q <= `URX_LCTRL_RST;
      div_q   <= `URX_DIV_RST;
      imask_q <= 4'h0;
    end else if (wr_en) begin
      if (hit(addr, `URX_OFS_LCTRL)) begin
        lctrl_q <= wr_data[7:0];
      end
      // below four clocks a bit the half-bit sample point collapses
      if (hit(addr, `URX_OFS_DIV) && wr_data[15:2] != 14'h0) begin
        div_q <= wr_data[15:0];
      end
      if (hit(addr, `URX_OFS_IMASK)) begin
        imask_q <= wr_data[3:0];
      end
    end
  end

  // receive queue storage, errors kept beside each character
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wptr_q] <= rif.ent;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= 5'h00;
    end else begin
      // a full queue takes nothing, so the stored characters stay valid
      if (push) begin
        wptr_q <= wptr_q + `URX_PTR_W'h1;
      end
      if (pop) begin
        rptr_q <= rptr_q + `URX_PTR_W'h1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 5'h01;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end

  // overrun flag seen in the data word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      oe_dw_q <= 1'b0;
    end else if (ovr) begin
      oe_dw_q <= 1'b1;
    end else if (!full) begin
      oe_dw_q <= 1'b0;
    end
  end

  // status is loaded from the character being read; a new overrun beats a clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsr_q <= 4'h0;
    end else begin
      rsr_q <= (clr_wr ? 4'h0 : rsr_q)
             | {ovr, pop & head.be, pop & head.pe, pop & head.fe};
    end
  end

  // sticky interrupt bits, write one to clear, an event wins over the clear
  for (genvar i = 0; i < 4; i++) begin : g_ist
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        istat_q[i] <= 1'b0;
      end else if (ev[i]) begin
        istat_q[i] <= 1'b1;
      end else if (wr_en && hit(addr, `URX_OFS_ISTAT) && wr_data[i]) begin
        istat_q[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(istat_q & imask_q);
    end
  end

  // transmit hand-off
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_data_q  <= 8'h00;
      tx_valid_q <= 1'b0;
    end else begin
      tx_valid_q <= wr_en && hit(addr, `URX_OFS_DATA);
      if (wr_en && hit(addr, `URX_OFS_DATA)) begin
        tx_data_q <= wr_data[7:0];
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_data_d = 32'h0;
    if (hit(addr, `URX_OFS_DATA)) begin
      rd_data_d[`URX_DW_OE] = oe_dw_q;
      if (cnt_q != 5'h00) begin
        rd_data_d[10:0] = head;
      end
    end else if (hit(addr, `URX_OFS_STAT)) begin
      rd_data_d[3:0] = rsr_q;
    end else if (hit(addr, `URX_OFS_ISTAT)) begin
      rd_data_d[3:0] = istat_q;
    end else if (hit(addr, `URX_OFS_IMASK)) begin
      rd_data_d[3:0] = imask_q;
    end else if (hit(addr, `URX_OFS_LCTRL)) begin
      rd_data_d[7:0] = lctrl_q;
    end else if (hit(addr, `URX_OFS_DIV)) begin
      rd_data_d[15:0] = div_q;
    end
  end

  // read data stands for one cycle only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_q <= 32'h0;
    end else begin
      rd_data_q <= rd_en ? rd_data_d : 32'h0;
    end
  end

  data_char_a: assert property (@(posedge clk) disable iff (sys_rst)
    pop |=> rd_data_q[7:0] == $past(head.chr))
    else $error("read char mismatch");
  tx_queue_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_en && addr == 8'h00 |=> tx_valid_q && tx_data_q == $past(wr_data[7:0]))
    else $error("write not queued");
  dw_frame_a: assert property (@(posedge clk) disable iff (sys_rst)
    pop |=> rd_data_q[8] == $past(head.fe))
    else $error("framing bit mismatch");
  rsr_frame_a: assert property (@(posedge clk) disable iff (sys_rst)
    pop && head.fe |=> rsr_q[0])
    else $error("status framing not set");
  dw_parity_a: assert property (@(posedge clk) disable iff (sys_rst)
    pop |=> rd_data_q[9] == $past(head.pe))
    else $error("parity bit mismatch");
  dw_break_a: assert property (@(posedge clk) disable iff (sys_rst)
    pop |=> rd_data_q[10] == $past(head.be))
    else $error("break bit mismatch");
  ovr_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    rif.done && cnt_q >= depth |=> oe_dw_q && rsr_q[3])
    else $error("overrun not flagged");
  ovr_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    ovr && !pop |=> cnt_q == $past(cnt_q) && wptr_q == $past(wptr_q))
    else $error("full queue written");
  ovr_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    oe_dw_q && cnt_q < depth && !rif.done |=> !oe_dw_q)
    else $error("overrun bit stuck");
  fifo_store_a: assert property (@(posedge clk) disable iff (sys_rst)
    push |=> mem_q[$past(wptr_q)] == $past(rif.ent))
    else $error("entry not stored");
  clr_err_a: assert property (@(posedge clk) disable iff (sys_rst)
    clr_wr |=> rsr_q[2:0] == 3'h0)
    else $error("error bits not cleared");
  clr_ovr_a: assert property (@(posedge clk) disable iff (sys_rst)
    clr_wr && !ovr |=> !rsr_q[3])
    else $error("overrun not cleared");
  upper_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    rd_en && addr[7:3] == 5'h00 |=> rd_data_q[31:12] == 20'h0)
    else $error("upper bits not zero");

  // bookkeeping around the queue, the status bits, the outputs and the divisor floor
  tx_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(wr_en && hit(addr, `URX_OFS_DATA)) |=> !tx_valid_q)
    else $error("transmit strobe without write");
  tx_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(wr_en && hit(addr, `URX_OFS_DATA)) |=> tx_data_q == $past(tx_data_q))
    else $error("transmit data changed");
  empty_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    rd_en && hit(addr, `URX_OFS_DATA) && cnt_q == 5'h00 |=> rd_data_q[10:0] == 11'h000)
    else $error("empty queue read not zero");
  dw_ovr_a: assert property (@(posedge clk) disable iff (sys_rst)
    rd_en && hit(addr, `URX_OFS_DATA) |=> rd_data_q[11] == $past(oe_dw_q))
    else $error("data word overrun bit wrong");
  ovr_istat_a: assert property (@(posedge clk) disable iff (sys_rst)
    ovr |=> istat_q[3])
    else $error("overrun event lost");
  ovr_pop_a: assert property (@(posedge clk) disable iff (sys_rst)
    ovr && pop |=> cnt_q == $past(cnt_q) - 5'h01)
    else $error("overrun character stored");
  cnt_bound_a: assert property (@(posedge clk) disable iff (sys_rst)
    cnt_q <= 5'h10)
    else $error("queue count past depth");
  ovr_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    oe_dw_q && full |=> oe_dw_q)
    else $error("overrun bit dropped while full");
  ovr_rise_a: assert property (@(posedge clk) disable iff (sys_rst)
    !oe_dw_q && !ovr |=> !oe_dw_q)
    else $error("overrun bit without overrun");
  push_cnt_a: assert property (@(posedge clk) disable iff (sys_rst)
    push && !pop |=> cnt_q == $past(cnt_q) + 5'h01)
    else $error("push not counted");
  pop_cnt_a: assert property (@(posedge clk) disable iff (sys_rst)
    pop && !push |=> cnt_q == $past(cnt_q) - 5'h01)
    else $error("pop not counted");
  rptr_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    pop |=> rptr_q == $past(rptr_q) + `URX_PTR_W'h1)
    else $error("read pointer not advanced");
  wptr_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    push |=> wptr_q == $past(wptr_q) + `URX_PTR_W'h1)
    else $error("write pointer not advanced");
  rsr_par_a: assert property (@(posedge clk) disable iff (sys_rst)
    pop && head.pe |=> rsr_q[1])
    else $error("status parity not set");
  rsr_brk_a: assert property (@(posedge clk) disable iff (sys_rst)
    pop && head.be |=> rsr_q[2])
    else $error("status break not set");
  rsr_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    !clr_wr && !pop && !ovr |=> rsr_q == $past(rsr_q))
    else $error("status changed without cause");
  rsr_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    rd_en && hit(addr, `URX_OFS_STAT) |=> rd_data_q == {28'h0, $past(rsr_q)})
    else $error("status read mismatch");
  ovr_wins_a: assert property (@(posedge clk) disable iff (sys_rst)
    clr_wr && ovr |=> rsr_q[3])
    else $error("overrun lost to clear");
  ist_brk_a: assert property (@(posedge clk) disable iff (sys_rst)
    rif.done && rif.ent.be |=> istat_q[2])
    else $error("break event lost");
  ist_frame_a: assert property (@(posedge clk) disable iff (sys_rst)
    rif.done && rif.ent.fe |=> istat_q[0])
    else $error("framing event lost");
  ist_par_a: assert property (@(posedge clk) disable iff (sys_rst)
    rif.done && rif.ent.pe |=> istat_q[1])
    else $error("parity event lost");
  rd_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    !rd_en |=> rd_data_q == 32'h0)
    else $error("read data without read");
  irq_level_a: assert property (@(posedge clk) disable iff (sys_rst)
    (istat_q & imask_q) != 4'h0 |=> irq_q)
    else $error("interrupt not raised");
  irq_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    (istat_q & imask_q) == 4'h0 |=> !irq_q)
    else $error("interrupt without cause");
  div_floor_a: assert property (@(posedge clk) disable iff (sys_rst)
    div_q[15:2] != 14'h0)
    else $error("divisor below floor");
endmodule

// [hw/urx_pkg.sv]
package urx_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP, ST_BRKCHK, ST_BRKWAIT
  } urx_state_t;
  typedef struct packed {
    logic       be;
    logic       pe;
    logic       fe;
    logic [7:0] chr;
  } urx_entry_t;
endpackage

// [hw/urx_rx_core.sv]
`timescale 1ns/1ps
module urx_rx_core (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial line
  input wire logic rxd,
  // towards the register side
  urx_rx_if.rx     rif
);
  logic                s1_q, s2_q, s3_q, line_q;
  urx_pkg::urx_state_t state_q;
  logic [15:0]         cnt_q;
  logic [2:0]          bit_q;
  logic [7:0]          shf_q;
  logic                par_q;
  logic                tick, half;

  function automatic logic par_bad(input logic [7:0] d, input logic p,
                                   input logic eps, input logic sps);
    logic exp;
    exp = sps ? ~eps : (eps ? ^d : ~(^d));
    return p != exp;
  endfunction

  assign tick = cnt_q == rif.div - 16'h1;
  assign half = cnt_q == {1'b0, rif.div[15:1]};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= rxd;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a level only counts once the last two stages agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      line_q <= 1'b1;
    end else if (s2_q == s3_q) begin
      line_q <= s3_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q  <= urx_pkg::ST_IDLE;
      cnt_q    <= 16'h0;
      bit_q    <= 3'h0;
      shf_q    <= 8'h0;
      par_q    <= 1'b0;
      rif.done <= 1'b0;
      rif.ent  <= '0;
    end else begin
      rif.done <= 1'b0;
      unique case (state_q)
        urx_pkg::ST_IDLE: begin
          cnt_q <= 16'h0;
          if (!line_q) begin
            state_q <= urx_pkg::ST_START;
          end
        end
        urx_pkg::ST_START: begin
          if (half) begin
            cnt_q   <= 16'h0;
            bit_q   <= 3'h0;
            // a glitch shorter than half a bit is not a start
            state_q <= line_q ? urx_pkg::ST_IDLE : urx_pkg::ST_DATA;
          end else begin
            cnt_q <= cnt_q + 16'h1;
          end
        end
        urx_pkg::ST_DATA: begin
          if (tick) begin
            cnt_q <= 16'h0;
            shf_q <= {line_q, shf_q[7:1]};
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              state_q <= rif.pen ? urx_pkg::ST_PAR : urx_pkg::ST_STOP;
            end
          end else begin
            cnt_q <= cnt_q + 16'h1;
          end
        end
        urx_pkg::ST_PAR: begin
          if (tick) begin
            cnt_q   <= 16'h0;
            par_q   <= line_q;
            state_q <= urx_pkg::ST_STOP;
          end else begin
            cnt_q <= cnt_q + 16'h1;
          end
        end
        urx_pkg::ST_STOP: begin
          if (tick) begin
            cnt_q <= 16'h0;
            if (line_q) begin
              rif.done    <= 1'b1;
              rif.ent.chr <= shf_q;
              rif.ent.fe  <= 1'b0;
              rif.ent.be  <= 1'b0;
              rif.ent.pe  <= rif.pen && par_bad(shf_q, par_q, rif.eps, rif.sps);
              state_q     <= urx_pkg::ST_IDLE;
            end else if (shf_q == 8'h0 && !(rif.pen && par_q)) begin
              state_q <= urx_pkg::ST_BRKCHK;
            end else begin
              rif.done    <= 1'b1;
              rif.ent.chr <= shf_q;
              rif.ent.fe  <= 1'b1;
              rif.ent.be  <= 1'b0;
              rif.ent.pe  <= rif.pen && par_bad(shf_q, par_q, rif.eps, rif.sps);
              state_q     <= urx_pkg::ST_IDLE;
            end
          end else begin
            cnt_q <= cnt_q + 16'h1;
          end
        end
        urx_pkg::ST_BRKCHK: begin
          // low for a whole character, from the start edge to the end of the stop bit, is a break
          if (line_q) begin
            rif.done <= 1'b1;
            rif.ent  <= '{be: 1'b0, pe: 1'b0, fe: 1'b1, chr: 8'h00};
            state_q  <= urx_pkg::ST_IDLE;
          end else if (half) begin
            rif.done <= 1'b1;
            rif.ent  <= '{be: 1'b1, pe: 1'b0, fe: 1'b1, chr: 8'h00};
            state_q  <= urx_pkg::ST_BRKWAIT;
          end else begin
            cnt_q <= cnt_q + 16'h1;
          end
        end
        urx_pkg::ST_BRKWAIT: begin
          if (line_q) begin
            state_q <= urx_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= urx_pkg::ST_IDLE;
        end
      endcase
    end
  end

  brk_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    rif.done && rif.ent.be |-> rif.ent.chr == 8'h00 && rif.ent.fe)
    else $error("break char not zero");
  brk_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == urx_pkg::ST_BRKWAIT && !line_q |=> state_q == urx_pkg::ST_BRKWAIT && !rif.done)
    else $error("left break wait while line low");
  brk_detect_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == urx_pkg::ST_BRKCHK && !line_q && half |=> rif.done && rif.ent.be)
    else $error("break not reported");
  stop_ok_a: assert property (@(posedge clk) disable iff (sys_rst)
    state_q == urx_pkg::ST_STOP && tick && line_q |=> rif.done && !rif.ent.fe)
    else $error("good stop flagged");
  par_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    rif.done && !rif.pen |-> !rif.ent.pe)
    else $error("parity error without parity");
endmodule

// [hw/urx_rx_if.sv]
`timescale 1ns/1ps
interface urx_rx_if;
  logic [15:0]         div;
  logic                pen;
  logic                eps;
  logic                sps;
  logic                done;
  urx_pkg::urx_entry_t ent;
  modport ctl (output div, pen, eps, sps, input done, ent);
  modport rx (input div, pen, eps, sps, output done, ent);
endinterface

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "urx_cfg.svh"
module tb_top;
  localparam int BIT_CLKS = 8;
  logic        clk;
  logic        sys_rst;
  logic [7:0]  addr;
  logic [31:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_data;
  logic        rxd;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        irq;
  logic [31:0] seen;
  logic [7:0]  ch;
  logic [7:0]  modes [4] = '{8'h12, 8'h16, 8'h92, 8'h96};
  int          n_errors = 0;
  int          check_count = 0;

  urx_data_status dut (
    .clk     (clk),
    .sys_rst (sys_rst),
    .addr    (addr),
    .wr_data (wr_data),
    .wr_en   (wr_en),
    .rd_en   (rd_en),
    .rd_data (rd_data),
    .rxd     (rxd),
    .tx_data (tx_data),
    .tx_valid(tx_valid),
    .irq     (irq)
  );

  urx_serial_src #(.BIT_CLKS(BIT_CLKS)) src (
    .clk(clk),
    .rxd(rxd)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic complete_run();
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask

  // the #1 lets the edge that takes the strobe land before anything is looked at
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    check(name, exp, v);
  endtask

  function automatic logic par_of(input logic [7:0] d, input logic [7:0] lc);
    if (lc[`URX_LC_SPS]) return ~lc[`URX_LC_EPS];
    return lc[`URX_LC_EPS] ? ^d : ~^d;
  endfunction

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  initial begin
    sys_rst = 1'b1;
    addr = 8'h00;
    wr_data = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk("data_reset", `URX_OFS_DATA, 32'h0);
    rdchk("status_reset", `URX_OFS_STAT, 32'h0);
    rdchk("unmapped", 8'h08, 32'h0);
    wr(`URX_OFS_DATA, 32'hffff_ff5a);
    check("tx_valid", 32'h1, {31'h0, tx_valid});
    check("tx_data", 32'h5a, {24'h0, tx_data});
    @(posedge clk);
    #1;
    check("tx_valid_end", 32'h0, {31'h0, tx_valid});
    wr(`URX_OFS_DIV, 32'(BIT_CLKS));
    // every parity mode, a good and a bad character queued before either is read
    foreach (modes[m]) begin
      wr(`URX_OFS_LCTRL, {24'h0, modes[m]});
      ch = 8'h3c + 8'(m);
      src.send(ch, 1'b1, par_of(ch, modes[m]), 1'b1);
      src.send(~ch, 1'b1, ~par_of(~ch, modes[m]), 1'b1);
      rdchk("parity_ok", `URX_OFS_DATA, {24'h0, ch});
      rdchk("parity_bad", `URX_OFS_DATA, {24'h2, ~ch});
    end
    rdchk("status_parity", `URX_OFS_STAT, 32'h2);
    wr(`URX_OFS_STAT, 32'h0);
    rdchk("status_clr", `URX_OFS_STAT, 32'h0);
    wr(`URX_OFS_LCTRL, 32'h10);
    src.send(8'h81, 1'b0, 1'b0, 1'b0);
    rdchk("framing", `URX_OFS_DATA, 32'h181);
    rdchk("status_framing", `URX_OFS_STAT, 32'h1);
    wr(`URX_OFS_STAT, 32'hffff_ffff);
    rdchk("status_clr2", `URX_OFS_STAT, 32'h0);
    // a break much longer than a character must still leave a single entry
    src.hold_low(24);
    rdchk("break_char", `URX_OFS_DATA, 32'h500);
    rdchk("break_once", `URX_OFS_DATA, 32'h0);
    rdchk("status_break", `URX_OFS_STAT, 32'h5);
    src.send(8'h5a, 1'b0, 1'b0, 1'b1);
    rdchk("after_break", `URX_OFS_DATA, 32'h5a);
    wr(`URX_OFS_STAT, 32'h0);
    wr(`URX_OFS_ISTAT, 32'hf);
    wr(`URX_OFS_IMASK, 32'h0);
    // one character more than the queue holds
    for (int i = 0; i < 17; i++) src.send(8'h20 + 8'(i), 1'b0, 1'b0, 1'b1);
    rdchk("overrun_status", `URX_OFS_STAT, 32'h8);
    check("irq_masked", 32'h0, {31'h0, irq});
    rdchk("int_status", `URX_OFS_ISTAT, 32'h8);
    wr(`URX_OFS_IMASK, 32'h8);
    @(posedge clk);
    #1;
    check("irq_set", 32'h1, {31'h0, irq});
    // the queue is still full here, so the overrun bit stands beside the oldest character
    rd(`URX_OFS_DATA, seen);
    check("head_kept", 32'h820, seen);
    src.send(8'h77, 1'b0, 1'b0, 1'b1);
    for (int i = 1; i < 16; i++) rdchk("drain", `URX_OFS_DATA, 32'h20 + i);
    rdchk("after_drain", `URX_OFS_DATA, 32'h77);
    rdchk("empty", `URX_OFS_DATA, 32'h0);
    wr(`URX_OFS_STAT, 32'h1234_5678);
    rdchk("oe_clr", `URX_OFS_STAT, 32'h0);
    // single holding slot: the second character overruns and the first survives
    wr(`URX_OFS_LCTRL, 32'h0);
    src.send(8'h41, 1'b0, 1'b0, 1'b1);
    src.send(8'h42, 1'b0, 1'b0, 1'b1);
    rdchk("slot_kept", `URX_OFS_DATA, 32'h841);
    rdchk("slot_oe_clr", `URX_OFS_DATA, 32'h0);
    rdchk("slot_status", `URX_OFS_STAT, 32'h8);
    wr(`URX_OFS_ISTAT, 32'h8);
    @(posedge clk);
    #1;
    check("irq_clr", 32'h0, {31'h0, irq});
    complete_run();
  end
endmodule

// [tb/urx_serial_src.sv]
`timescale 1ns/1ps
// remote transmitter on the receive line, idles high (marking) between frames
module urx_serial_src #(
  parameter int BIT_CLKS = 8
) (
  // clock
  input  wire logic clk,
  // serial line
  output logic      rxd
);
  initial rxd = 1'b1;

  task automatic put_bit(input logic v);
    @(posedge clk);
    rxd <= v;
    repeat (BIT_CLKS - 1) @(posedge clk);
  endtask

  // parity and stop come from the caller so a scenario can send wrong ones on purpose
  task automatic send(input logic [7:0] d, input logic par_en, input logic par_bit,
                      input logic stop_bit);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++) put_bit(d[i]);
    if (par_en) put_bit(par_bit);
    put_bit(stop_bit);
    put_bit(1'b1);
  endtask

  task automatic hold_low(input int bits);
    repeat (bits) put_bit(1'b0);
    repeat (2) put_bit(1'b1);
  endtask
endmodule
